//--- pkg/rtc_value_pkg.sv
// shared constants for the time value register block
package rtc_value_pkg;

    // register bus shape
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;

    // register offsets
    localparam logic [3:0] CTRL_OFS   = 4'h0;
    localparam logic [3:0] WINDOW_OFS = 4'h1;

    // control register fields and reset values, plus the read data reset value
    localparam int          PTR_LSB    = 0;
    localparam int          UNLOCK_BIT = 8;
    localparam logic [1:0]  PTR_RST    = 2'h0;
    localparam logic        UNLOCK_RST = 1'b0;
    localparam logic [15:0] RD_RST     = 16'h0000;

    // value pointer codes
    localparam logic [1:0] PTR_MIN_SEC  = 2'h0;
    localparam logic [1:0] PTR_WEEKDAY_DIGIT_HR  = 2'h1;

    // implemented bits of each value register
    localparam logic [15:0] WKHR_MASK = 16'h073F;
    localparam logic [15:0] MS_MASK   = 16'h7F7F;

    // digit table: sec1, sec10, min1, min10, hr1, hr10, weekday
    localparam int NUM_DIG = 7;
    localparam int DIG_LSB [NUM_DIG] = '{0, 4, 8, 12, 0, 4, 8};
    localparam logic [3:0] DIG_FMASK [NUM_DIG] =
        '{4'hF, 4'h7, 4'hF, 4'h7, 4'hF, 4'h3, 4'h7};
    localparam logic [3:0] DIG_MAX [NUM_DIG] =
        '{4'h9, 4'h5, 4'h9, 4'h5, 4'h9, 4'h2, 4'h6};
    localparam logic DIG_IN_WH [NUM_DIG] =
        '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};

    // digit indices
    localparam int SEC1_IDX = 0;
    localparam int SEC10_IDX = 1;
    localparam int MIN1_IDX = 2;
    localparam int MIN10_IDX = 3;
    localparam int HR1_IDX  = 4;
    localparam int HR10_IDX = 5;
    localparam int WEEKDAY_DIGIT_IDX = 6;

    // last hour ones value of the day (hour 23)
    localparam logic [3:0] HR1_DAYEND = 4'h3;

endpackage : rtc_value_pkg

//--- hw/bcd_digit.sv
// one bcd time digit with load and wrapping increment
`timescale 1ns/10ps
module bcd_digit
(
    input  wire logic       clk,
    input  wire logic       ld,
    input  wire logic [3:0] ld_val,
    input  wire logic       inc,
    input  wire logic [3:0] lim,
    output logic      [3:0] val_ff,
    output logic            at_lim
);

    // digit sits on its last value, next increment wraps
    assign at_lim = (val_ff == lim);

    // no reset: contents unknown until software loads them
    always_ff @(posedge clk)
    begin
        if (ld)
        begin
            val_ff <= ld_val; // write beats count
        end
        else if (inc)
        begin
            val_ff <= at_lim ? 4'h0 : 4'(val_ff + 4'h1);
        end
    end

endmodule : bcd_digit

//--- hw/rtc_time_value_regs.sv
// time value registers of the real-time clock, behind a pointer window
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/10ps
module rtc_time_value_regs
    import rtc_value_pkg::*;
(
    input  wire logic                          clk,
    input  wire logic                          rst_b,
    input  wire logic [rtc_value_pkg::ADDR_W-1:0] addr,
    input  wire logic [rtc_value_pkg::DATA_W-1:0] wr_data,
    input  wire logic                          wr_stb,
    input  wire logic                          rd_stb,
    input  wire logic                          second_tick,
    output logic      [rtc_value_pkg::DATA_W-1:0] rd_data_ff
);

    import rtc_value_pkg::*;

    // control state
    logic [1:0]        value_pointer_ff;
    logic              write_unlock_ff;

    // access decode
    logic              sel_ctrl;
    logic              sel_window;
    logic              ld_wh;
    logic              ld_ms;
    logic              ld_any;

    // digit storage and counting chain
    logic [3:0]        dig    [NUM_DIG];
    logic              at_lim [NUM_DIG];
    logic [NUM_DIG-1:0] inc;

    // views of the two value registers and the control register, and the read mux output
    logic [DATA_W-1:0] wkhr_view;
    logic [DATA_W-1:0] ms_view;
    logic [DATA_W-1:0] ctrl_view;
    logic [DATA_W-1:0] nxt_rd_data;

    // address decode
    assign sel_ctrl   = (addr == CTRL_OFS);
    assign sel_window = (addr == WINDOW_OFS);

    // window writes steered by pointer and gated by unlock
    assign ld_wh = wr_stb && sel_window && write_unlock_ff
                   && (value_pointer_ff == PTR_WEEKDAY_DIGIT_HR);
    assign ld_ms = wr_stb && sel_window && write_unlock_ff
                   && (value_pointer_ff == PTR_MIN_SEC);
    assign ld_any = ld_wh || ld_ms;

    // pointer and unlock live in the control register
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            value_pointer_ff <= PTR_RST;
            write_unlock_ff  <= UNLOCK_RST;
        end
        else if (wr_stb && sel_ctrl)
        begin
            value_pointer_ff <= wr_data[PTR_LSB +: 2];
            write_unlock_ff  <= wr_data[UNLOCK_BIT];
        end
    end

    // seconds tick enters the bottom of the carry chain
    assign inc[0] = second_tick;

    // one counter per digit, carries ripple upward
    generate
        for (genvar g = 0; g < NUM_DIG; g++)
        begin : g_dig
            logic [3:0] lim;
            logic       ld;
            logic [3:0] ld_val;

            // hour ones wraps at 3 once hour tens reaches 2
            if (g == HR1_IDX)
            begin : g_hr1
                assign lim = (dig[HR10_IDX] == DIG_MAX[HR10_IDX])
                             ? HR1_DAYEND : DIG_MAX[g];
            end
            else
            begin : g_std
                assign lim = DIG_MAX[g];
            end

            // field extracted from the written word
            assign ld     = DIG_IN_WH[g] ? ld_wh : ld_ms;
            assign ld_val = 4'(wr_data >> DIG_LSB[g]) & DIG_FMASK[g];

            bcd_digit u_digit
            (
                .clk    (clk),
                .ld     (ld),
                .ld_val (ld_val),
                .inc    (inc[g]),
                .lim    (lim),
                .val_ff (dig[g]),
                .at_lim (at_lim[g])
            );

            // carry to the next digit up
            if (g < NUM_DIG - 1)
            begin : g_carry
                assign inc[g+1] = inc[g] & at_lim[g];
            end
        end
    endgenerate

    // weekday/hours layout, unused bits zero
    assign wkhr_view = {5'h00,
                        dig[WEEKDAY_DIGIT_IDX][2:0],
                        2'h0,
                        dig[HR10_IDX][1:0],
                        dig[HR1_IDX]};

    // minutes/seconds layout, unused bits zero
    assign ms_view = {1'b0,
                      dig[MIN10_IDX][2:0],
                      dig[MIN1_IDX],
                      1'b0,
                      dig[SEC10_IDX][2:0],
                      dig[SEC1_IDX]};

    // control register readback
    always_comb
    begin
        ctrl_view = '0;
        ctrl_view[PTR_LSB +: 2]  = value_pointer_ff;
        ctrl_view[UNLOCK_BIT]    = write_unlock_ff;
    end

    // read mux, data valid only in the cycle after the strobe
    always_comb
    begin
        nxt_rd_data = RD_RST;
        if (rd_stb)
        begin
            if (sel_ctrl)
            begin
                nxt_rd_data = ctrl_view;
            end
            else if (sel_window)
            begin
                unique case (value_pointer_ff)
                    PTR_WEEKDAY_DIGIT_HR: nxt_rd_data = wkhr_view;
                    PTR_MIN_SEC: nxt_rd_data = ms_view;
                    default:     nxt_rd_data = RD_RST;
                endcase
            end
        end
    end

    // registered read data
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            rd_data_ff <= RD_RST;
        end
        else
        begin
            rd_data_ff <= nxt_rd_data;
        end
    end

    // write then read of weekday/hours returns the masked value
    AST_WKHR_WR_RD: assert property (
        @(posedge clk) disable iff (!rst_b)
        (wr_stb && sel_window && write_unlock_ff
         && value_pointer_ff == PTR_WEEKDAY_DIGIT_HR)
        ##1 (rd_stb && sel_window && !wr_stb
             && value_pointer_ff == PTR_WEEKDAY_DIGIT_HR && !second_tick)
        |=> rd_data_ff == ($past(wr_data, 2) & WKHR_MASK))
        else $error("weekday/hours readback differs from write");

    // write then read of minutes/seconds returns the masked value
    AST_MS_WR_RD: assert property (
        @(posedge clk) disable iff (!rst_b)
        (wr_stb && sel_window && write_unlock_ff
         && value_pointer_ff == PTR_MIN_SEC)
        ##1 (rd_stb && sel_window && !wr_stb
             && value_pointer_ff == PTR_MIN_SEC && !second_tick)
        |=> rd_data_ff == ($past(wr_data, 2) & MS_MASK))
        else $error("minutes/seconds readback differs from write");

    // locked writes change no digit
    AST_LOCKED_WR: assert property (
        @(posedge clk) disable iff (!rst_b)
        (wr_stb && sel_window && !write_unlock_ff && !second_tick)
        |=> $stable(wkhr_view) && $stable(ms_view))
        else $error("time value changed by a locked write");

    // locked write gives no read data either
    AST_LOCKED_QUIET: assert property (
        @(posedge clk) disable iff (!rst_b)
        (wr_stb && !write_unlock_ff) |=> rd_data_ff == RD_RST)
        else $error("locked write produced read data");

    // unused weekday/hours bits read as zero
    AST_WKHR_ZERO: assert property (
        @(posedge clk) disable iff (!rst_b)
        (rd_stb && sel_window && value_pointer_ff == PTR_WEEKDAY_DIGIT_HR)
        |=> (rd_data_ff & ~WKHR_MASK) == 16'h0000)
        else $error("unused weekday/hours bit read as one");

    // unused minutes/seconds bits read as zero
    AST_MS_ZERO: assert property (
        @(posedge clk) disable iff (!rst_b)
        (rd_stb && sel_window && value_pointer_ff == PTR_MIN_SEC)
        |=> (rd_data_ff & ~MS_MASK) == 16'h0000)
        else $error("unused minutes/seconds bit read as one");

    // second ones wraps from 9 to 0 and bumps second tens
    AST_SEC1_WRAP: assert property (
        @(posedge clk) disable iff (!rst_b)
        (second_tick && !ld_any && dig[SEC1_IDX] == 4'h9
         && dig[SEC10_IDX] == 4'h2)
        |=> dig[SEC1_IDX] == 4'h0 && dig[SEC10_IDX] == 4'h3)
        else $error("second ones digit failed to wrap");

    // second tens wraps past 5 and advances minutes
    AST_SEC10_WRAP: assert property (
        @(posedge clk) disable iff (!rst_b)
        (second_tick && !ld_any && ms_view == 16'h1259)
        |=> ms_view == 16'h1300)
        else $error("second tens digit failed to wrap");

    // 59:59 rolls to 00:00 and advances the hour
    AST_MIN_WRAP: assert property (
        @(posedge clk) disable iff (!rst_b)
        (second_tick && !ld_any && ms_view == 16'h5959
         && wkhr_view == 16'h0209)
        |=> ms_view == 16'h0000 && wkhr_view == 16'h0210)
        else $error("minute rollover wrong");

    // end of day: 23 rolls to 00 and weekday advances
    AST_DAY_WRAP: assert property (
        @(posedge clk) disable iff (!rst_b)
        (second_tick && !ld_any && ms_view == 16'h5959
         && wkhr_view == 16'h0323)
        |=> wkhr_view == 16'h0400)
        else $error("hour rollover wrong");

    // last weekday wraps back to zero
    AST_WEEKDAY_DIGIT_WRAP: assert property (
        @(posedge clk) disable iff (!rst_b)
        (second_tick && !ld_any && ms_view == 16'h5959
         && wkhr_view == 16'h0623)
        |=> wkhr_view == 16'h0000)
        else $error("weekday rollover wrong");

    // hour ones counts through 9 below hour 20
    AST_HR1_NINE: assert property (
        @(posedge clk) disable iff (!rst_b)
        (second_tick && !ld_any && ms_view == 16'h5959
         && wkhr_view == 16'h0119)
        |=> wkhr_view == 16'h0120)
        else $error("hour ones rollover wrong");

    // minute ones wraps from 9 into minute tens
    AST_MIN1_WRAP: assert property (
        @(posedge clk) disable iff (!rst_b)
        (second_tick && !ld_any && ms_view == 16'h1959)
        |=> ms_view == 16'h2000)
        else $error("minute ones rollover wrong");

    // unlocked weekday/hours write lands in the next cycle
    AST_WH_LOAD: assert property (
        @(posedge clk) disable iff (!rst_b)
        ld_wh |=> wkhr_view == ($past(wr_data) & WKHR_MASK))
        else $error("weekday/hours write did not land");

    // unlocked minutes/seconds write lands in the next cycle
    AST_MS_LOAD: assert property (
        @(posedge clk) disable iff (!rst_b)
        ld_ms |=> ms_view == ($past(wr_data) & MS_MASK))
        else $error("minutes/seconds write did not land");

    // control write sets pointer and unlock
    AST_CTRL_WR: assert property (
        @(posedge clk) disable iff (!rst_b)
        (wr_stb && sel_ctrl)
        |=> write_unlock_ff == $past(wr_data[UNLOCK_BIT])
            && value_pointer_ff == $past(wr_data[PTR_LSB +: 2]))
        else $error("control write did not land");

    // control readback shows pointer and unlock, other bits zero
    AST_CTRL_RD: assert property (
        @(posedge clk) disable iff (!rst_b)
        (rd_stb && sel_ctrl)
        |=> rd_data_ff == {7'h00, $past(write_unlock_ff), 6'h00,
                           $past(value_pointer_ff)})
        else $error("control readback wrong");

    // pointer codes 10 and 11 map the window to nothing
    AST_PTR_UNMAPPED: assert property (
        @(posedge clk) disable iff (!rst_b)
        (rd_stb && sel_window && value_pointer_ff[1])
        |=> rd_data_ff == 16'h0000)
        else $error("unmapped pointer returned data");

    // read port stays quiet without a read strobe
    AST_RD_IDLE: assert property (
        @(posedge clk) disable iff (!rst_b)
        !rd_stb |=> rd_data_ff == 16'h0000)
        else $error("read data without a read strobe");

    // write to an unmapped address changes nothing
    AST_UNMAPPED_WR: assert property (
        @(posedge clk) disable iff (!rst_b)
        (wr_stb && !sel_ctrl && !sel_window && !second_tick)
        |=> $stable(wkhr_view) && $stable(ms_view)
            && $stable(value_pointer_ff) && $stable(write_unlock_ff))
        else $error("unmapped write changed state");

    // second ones steps by one below 9
    AST_SEC1_STEP: assert property (
        @(posedge clk) disable iff (!rst_b)
        (second_tick && !ld_any && dig[SEC1_IDX] < 4'h9)
        |=> dig[SEC1_IDX] == 4'($past(dig[SEC1_IDX]) + 4'h1))
        else $error("second ones digit failed to step");

    // out of reset the window is locked and read data is quiet
    AST_RST_STATE: assert property (
        @(posedge clk) disable iff (!rst_b)
        $rose(rst_b) |-> !write_unlock_ff && value_pointer_ff == PTR_RST
                         && rd_data_ff == RD_RST)
        else $error("control state wrong after reset");

endmodule : rtc_time_value_regs

//--- dv/tb_rtc_time_value_regs.sv
// self-checking bench for the time value register block
`timescale 1ns/10ps
module tb_rtc_time_value_regs;
    import rtc_value_pkg::*;

    logic              clk;
    logic              rst_b;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wr_data;
    logic              wr_stb;
    logic              rd_stb;
    logic              second_tick;
    logic [DATA_W-1:0] rd_data_ff;
    int                n_errors;
    int                compares;

    // device under test, every input driven
    rtc_time_value_regs i_rtc_time_value_regs
    (
        .clk         (clk),
        .rst_b       (rst_b),
        .addr        (addr),
        .wr_data     (wr_data),
        .wr_stb      (wr_stb),
        .rd_stb      (rd_stb),
        .second_tick (second_tick),
        .rd_data_ff  (rd_data_ff)
    );

    // 25 mhz clock
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // counts, verdict and end of run
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report

    // compare one 16-bit word
    task automatic chk(input string       name,
                       input logic [15:0] exp,
                       input logic [15:0] got);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // one-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr    <= a;
        wr_data <= d;
        wr_stb  <= 1'b1;
        @(posedge clk);
        wr_stb  <= 1'b0;
    endtask : wr

    // one-cycle read, called just after an edge; data stands one cycle
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1;
        chk("read data", exp, rd_data_ff);
        @(posedge clk);
        #1;
        chk("idle read data", 16'h0000, rd_data_ff);
    endtask : rd

    // control write: unlock bit 8, pointer bits 1:0
    task automatic ctl(input logic unl, input logic [1:0] p);
        wr(CTRL_OFS, {7'h00, unl, 6'h00, p});
    endtask : ctl

    // unlocked window write and read back through one pointer
    task automatic wrd(input logic [1:0]  p,
                       input logic [15:0] d,
                       input logic [15:0] exp);
        ctl(1'b1, p);
        wr(WINDOW_OFS, d);
        rd(WINDOW_OFS, exp);
    endtask : wrd

    // load both registers, one seconds tick, read both back
    task automatic roll(input logic [15:0] ms,
                        input logic [15:0] wh,
                        input logic [15:0] exp_ms,
                        input logic [15:0] exp_wh);
        wrd(PTR_MIN_SEC, ms, ms);
        wrd(PTR_WEEKDAY_DIGIT_HR, wh, wh);
        @(posedge clk);
        second_tick <= 1'b1;
        @(posedge clk);
        second_tick <= 1'b0;
        rd(WINDOW_OFS, exp_wh);
        ctl(1'b1, PTR_MIN_SEC);
        rd(WINDOW_OFS, exp_ms);
    endtask : roll

    // hang guard, far beyond the few hundred cycles needed
    initial
    begin
        repeat (3000) @(posedge clk);
        n_errors++;
        final_report();
    end

    // main sequence
    initial
    begin
        rst_b       = 1'b0;
        addr        = 4'h0;
        wr_data     = 16'h0000;
        wr_stb      = 1'b0;
        rd_stb      = 1'b0;
        second_tick = 1'b0;
        n_errors    = 0;
        compares    = 0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        rd(CTRL_OFS, 16'h0000);
        // field placement and top codes of each digit
        wrd(PTR_WEEKDAY_DIGIT_HR, 16'h0523, 16'h0523);
        wrd(PTR_WEEKDAY_DIGIT_HR, 16'h0629, 16'h0629);
        wrd(PTR_WEEKDAY_DIGIT_HR, 16'hF8C0, 16'h0000);
        wrd(PTR_MIN_SEC, 16'h5959, 16'h5959);
        wrd(PTR_MIN_SEC, 16'h8080, 16'h0000);
        wrd(PTR_MIN_SEC, 16'h3047, 16'h3047);
        ctl(1'b1, PTR_WEEKDAY_DIGIT_HR);
        rd(WINDOW_OFS, 16'h0000);
        // locked writes leave both registers alone
        wrd(PTR_WEEKDAY_DIGIT_HR, 16'h0215, 16'h0215);
        ctl(1'b0, PTR_WEEKDAY_DIGIT_HR);
        wr(WINDOW_OFS, 16'h0106);
        rd(WINDOW_OFS, 16'h0215);
        ctl(1'b0, PTR_MIN_SEC);
        wr(WINDOW_OFS, 16'h4321);
        rd(WINDOW_OFS, 16'h3047);
        rd(CTRL_OFS, 16'h0000);
        // pointer 10 and an unmapped address map to nothing
        ctl(1'b1, 2'h2);
        wr(WINDOW_OFS, 16'h1111);
        rd(WINDOW_OFS, 16'h0000);
        wr(4'hF, 16'h2222);
        rd(4'hF, 16'h0000);
        ctl(1'b1, PTR_MIN_SEC);
        rd(WINDOW_OFS, 16'h3047);
        rd(CTRL_OFS, 16'h0100);
        // seconds ticks through every carry of the chain
        roll(16'h3047, 16'h0215, 16'h3048, 16'h0215);
        roll(16'h1229, 16'h0215, 16'h1230, 16'h0215);
        roll(16'h1259, 16'h0215, 16'h1300, 16'h0215);
        roll(16'h1959, 16'h0215, 16'h2000, 16'h0215);
        roll(16'h5959, 16'h0209, 16'h0000, 16'h0210);
        roll(16'h5959, 16'h0119, 16'h0000, 16'h0120);
        roll(16'h5959, 16'h0323, 16'h0000, 16'h0400);
        // full rollover: 6 23:59:59 to 0 00:00:00
        roll(16'h5959, 16'h0623, 16'h0000, 16'h0000);
        final_report();
    end

endmodule : tb_rtc_time_value_regs
